/* verif/scwp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module scwp_host
  import scwp_pkg::*;
(
  // device side and host intent
  input wire logic dev_out_in,
  input wire logic dev_oe_n_in,
  input wire logic keep_awake_in,
  input wire scwp_pkg::scwp_rate_t rate_in,
  // wire level and host timeout arming
  output logic pin_out,
  output logic slow_link_out
);
  // wired-and with pull-up: an awake host holds the pin low to stay served
  assign pin_out = !((!dev_oe_n_in && !dev_out_in) || keep_awake_in);
  // a fallback rate arms the host's slow-link timeout
  assign slow_link_out = (rate_in == SCWP_RATE_250K);
endmodule
`default_nettype wire

/* verif/scwp_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module scwp_properties
  import scwp_pkg::*;
#(
  parameter int HOLD_COUNT = 50,
  parameter int FILTER_COUNT = 8,
  parameter int SHORT_COUNT = 10
)
(
  // watched top ports
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  input wire logic SLEEP_WAKE_PIN_IN,
  input wire logic QUEUE_STATUS_FAULT_IN,
  input wire logic RATE_BIAS_EN_OUT,
  input wire logic SLEEP_WAKE_PIN_OUT,
  input wire logic SLEEP_WAKE_PIN_OE_N_OUT,
  input wire logic SLEEP_REQ_OUT,
  input wire logic QUEUE_STATUS_SHORT_OUT,
  input wire scwp_pkg::scwp_rate_t CLOCK_RATE_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);
  logic [15:0] low_run;
  logic [15:0] high_run;
  logic [15:0] fault_run;
  // ==========================================================================
  // run lengths; the pin run only counts in normal operation, where it matters
  // ==========================================================================
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
    begin
      low_run <= 16'h0000;
      high_run <= 16'h0000;
      fault_run <= 16'h0000;
    end
    else
    begin
      low_run <= SLEEP_WAKE_PIN_OE_N_OUT ? 16'h0000 : low_run + 16'h0001;
      high_run <= (SLEEP_WAKE_PIN_IN && SLEEP_WAKE_PIN_OE_N_OUT && !RATE_BIAS_EN_OUT) ? high_run + 16'h0001 : 16'h0000;
      fault_run <= QUEUE_STATUS_FAULT_IN ? fault_run + 16'h0001 : 16'h0000;
    end
  end
  // ==========================================================================
  // properties
  // ==========================================================================
  chk_rate_frozen: assert property (!RATE_BIAS_EN_OUT && !$past(RATE_BIAS_EN_OUT) && !$past(RATE_BIAS_EN_OUT, 2)
    |-> $stable(CLOCK_RATE_OUT)) else $error("rate changed after capture");
  chk_pin_open_drain: assert property (!SLEEP_WAKE_PIN_OE_N_OUT |-> !SLEEP_WAKE_PIN_OUT && !RATE_BIAS_EN_OUT)
    else $error("pin drive wrong");
  chk_hold_length: assert property ($rose(SLEEP_WAKE_PIN_OE_N_OUT) |-> low_run == HOLD_COUNT)
    else $error("hold length wrong");
  chk_hold_bound: assert property (low_run <= HOLD_COUNT) else $error("hold too long");
  chk_no_sleep_hold: assert property (!SLEEP_WAKE_PIN_OE_N_OUT |-> !SLEEP_REQ_OUT) else $error("pin used in hold");
  chk_sleep_early: assert property ($rose(SLEEP_REQ_OUT) |-> high_run >= FILTER_COUNT)
    else $error("sleep request before filter time");
  chk_sleep_late: assert property (high_run >= FILTER_COUNT + 6 |-> SLEEP_REQ_OUT)
    else $error("sleep request missing");
  chk_sleep_sticky: assert property ($past(SLEEP_REQ_OUT) |-> SLEEP_REQ_OUT) else $error("sleep request dropped");
  chk_short_early: assert property ($rose(QUEUE_STATUS_SHORT_OUT) |-> fault_run >= SHORT_COUNT)
    else $error("short flagged early");
  chk_short_late: assert property (fault_run >= SHORT_COUNT + 6 |-> QUEUE_STATUS_SHORT_OUT)
    else $error("short not flagged");
  cover property ($rose(SLEEP_WAKE_PIN_OE_N_OUT));
  cover property ($rose(SLEEP_REQ_OUT));
  cover property ($rose(QUEUE_STATUS_SHORT_OUT));
endmodule
`default_nettype wire

/* verif/scwp_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module scwp_top_bench;
  import scwp_pkg::*;
  localparam int HOLD = 50;
  localparam int FILT = 8;
  localparam int SHRT = 10;
  logic clk, nrst, psel, pen, pwr, awake, fault, bist, err;
  logic pready, pslverr, bias, pin, pin_out, pin_oe_n, sleep, short, irq, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] code;
  scwp_rate_t rate, e;
  int fail_count, comparisons, seed, n, k;
  // ==========================================================================
  // clock, design, host
  // ==========================================================================
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  scwp_top #(.HOLD_COUNT(HOLD), .FILTER_COUNT(FILT), .SHORT_COUNT(SHRT)) u_dut (.CLOCK_IN(clk), .NRST_IN(nrst),
    .CE_IN(1'b1), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .COMP_CODE_IN(code),
    .COMP_BIST_FAIL_IN(bist), .RATE_BIAS_EN_OUT(bias), .SLEEP_WAKE_PIN_IN(pin), .SLEEP_WAKE_PIN_OUT(pin_out),
    .SLEEP_WAKE_PIN_OE_N_OUT(pin_oe_n), .QUEUE_STATUS_FAULT_IN(fault), .CLOCK_RATE_OUT(rate),
    .SLEEP_REQ_OUT(sleep), .QUEUE_STATUS_SHORT_OUT(short), .IRQ_OUT(irq));
  scwp_host u_host (.dev_out_in(pin_out), .dev_oe_n_in(pin_oe_n), .keep_awake_in(awake), .rate_in(rate),
    .pin_out(pin), .slow_link_out(slow));
  // ==========================================================================
  // helpers
  // ==========================================================================
  task final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task bail();
    fail_count++;
    final_report();
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
      if (t > 50) bail();
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // edges until released pin (0), sleep request (1) or short (2), bounded
  task wait_for(input int sel, input int lim);
    logic s;
    n = 0;
    s = 1'b0;
    while (!s)
    begin
      @(posedge clk);
      #1;
      n++;
      s = (sel == 0) ? (pin_oe_n === 1'b1) : (sel == 1) ? (sleep === 1'b1) : (short === 1'b1);
      if (n > lim) bail();
    end
  endtask
  function scwp_rate_t exp_rate(input logic [3:0] c, input logic b);
    if (b) return SCWP_RATE_250K;
    case (c)
      CODE_1MHZ: return SCWP_RATE_1M;
      CODE_4MHZ: return SCWP_RATE_4M;
      CODE_8MHZ: return SCWP_RATE_8M;
      default: return SCWP_RATE_250K;
    endcase
  endfunction
  // ==========================================================================
  // every code, then random codes; odd passes wake by the isolated link
  // ==========================================================================
  initial
  begin
    seed = 32'h1CC2E9C7;
    fail_count = 0;
    comparisons = 0;
    {nrst, psel, pen, pwr, fault, bist, paddr, pwdata, code} = '0;
    awake = 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk);
      nrst <= 1'b0;
      awake <= 1'b1;
      fault <= 1'b0;
      code <= (i < 16) ? i[3:0] : 4'($random(seed));
      bist <= (i >= 16) ? 1'($random(seed)) : (i == 9);
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      #1;
      check(bias, 1'b1);
      if (i == 0)
      begin
        apb(1'b0, REG_CONFIG, 32'h0);
        check(rd, CONFIG_RESET);
        apb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        check(err, 1'b1);
      end
      e = exp_rate(code, bist);
      apb(1'b1, REG_CONFIG, {30'h0, i[0], 1'b0});
      if (i[0])
      begin
        wait_for(0, 4 * HOLD);
        check(n, HOLD + 1);
      end
      @(posedge clk);
      code <= ~code;
      bist <= ~bist;
      repeat (3) @(posedge clk);
      #1;
      check(rate, e);
      check(bias, 1'b0);
      check(slow, (e == SCWP_RATE_250K));
      apb(1'b0, REG_STATE, 32'h0);
      check(rd[5:4], e);
      k = 1 + ($unsigned($random(seed)) % (FILT - 1));
      @(posedge clk);
      awake <= 1'b0;
      repeat (k) @(posedge clk);
      awake <= 1'b1;
      repeat (20) @(posedge clk);
      #1;
      check(sleep, 1'b0);
      @(posedge clk);
      awake <= 1'b0;
      wait_for(1, 4 * FILT);
      // two sync stages, the filter run, then the registered request
      check(n, FILT + 3);
      if (i == 0)
      begin
        @(posedge clk);
        awake <= 1'b1;
        apb(1'b1, REG_IRQ_MASK, 32'h1);
        #1;
        check(irq, 1'b1);
        apb(1'b1, REG_IRQ_MASK, 32'h0);
        #1;
        check(irq, 1'b0);
        apb(1'b1, REG_IRQ_STATUS, 32'h1);
        apb(1'b0, REG_IRQ_STATUS, 32'h0);
        check(rd[IRQ_SLEEP_BIT], 1'b0);
        @(posedge clk);
        fault <= 1'b1;
        repeat (SHRT - 3) @(posedge clk);
        fault <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        check(short, 1'b0);
        @(posedge clk);
        fault <= 1'b1;
        wait_for(2, 4 * SHRT);
        check(n, SHRT + 2);
        apb(1'b0, REG_IRQ_STATUS, 32'h0);
        check(rd[IRQ_SHORT_BIT], 1'b1);
      end
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule
bind scwp_top scwp_properties #(.HOLD_COUNT(HOLD_COUNT), .FILTER_COUNT(FILTER_COUNT), .SHORT_COUNT(SHORT_COUNT))
  u_props (.CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN), .SLEEP_WAKE_PIN_IN(SLEEP_WAKE_PIN_IN),
  .QUEUE_STATUS_FAULT_IN(QUEUE_STATUS_FAULT_IN), .RATE_BIAS_EN_OUT(RATE_BIAS_EN_OUT),
  .SLEEP_WAKE_PIN_OUT(SLEEP_WAKE_PIN_OUT), .SLEEP_WAKE_PIN_OE_N_OUT(SLEEP_WAKE_PIN_OE_N_OUT),
  .SLEEP_REQ_OUT(SLEEP_REQ_OUT), .QUEUE_STATUS_SHORT_OUT(QUEUE_STATUS_SHORT_OUT), .CLOCK_RATE_OUT(CLOCK_RATE_OUT));
`default_nettype wire

/* verilog/scwp_pkg.sv */
`default_nettype none
package scwp_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_FREQ_HZ = 200_000_000;
  localparam int HOLD_TIME_MS = 800;
  localparam int FILTER_TIME_US = 2;
  localparam int SHORT_TIME_US = 5;
  localparam int HOLD_CYCLES = HOLD_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int FILTER_CYCLES = FILTER_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int SHORT_CYCLES = SHORT_TIME_US * (CLK_FREQ_HZ / 1_000_000);

  // ==========================================================================
  // comparator codes and rate encoding
  // ==========================================================================
  localparam logic [3:0] CODE_1MHZ = 4'h1;
  localparam logic [3:0] CODE_4MHZ = 4'h3;
  localparam logic [3:0] CODE_8MHZ = 4'h7;
  localparam logic [3:0] CODE_SLOW = 4'h0;

  typedef enum logic [1:0]
  {
    SCWP_RATE_250K = 2'h0,
    SCWP_RATE_1M = 2'h1,
    SCWP_RATE_4M = 2'h2,
    SCWP_RATE_8M = 2'h3
  } scwp_rate_t;

  // ==========================================================================
  // open-drain pin carrier
  // ==========================================================================
  typedef struct packed
  {
    logic out;
    logic oe_n;
  } scwp_od_t;

  // ==========================================================================
  // APB map
  // ==========================================================================
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

  // config register bits
  localparam int CFG_PHASE_BIT = 0;
  localparam int CFG_ISO_WAKE_BIT = 1;
  // state register fields
  localparam int ST_CODE_LSB = 0;
  localparam int ST_RATE_LSB = 4;
  localparam int ST_BIST_FAIL_BIT = 6;
  localparam int ST_HOLD_BIT = 7;
  localparam int ST_PIN_BIT = 8;
  localparam int ST_SHORT_BIT = 9;
  // interrupt bits
  localparam int IRQ_SLEEP_BIT = 0;
  localparam int IRQ_SHORT_BIT = 1;
  localparam int IRQ_HOLD_DONE_BIT = 2;
  localparam int IRQ_WIDTH = 3;

  localparam logic [31:0] CONFIG_RESET = 32'h0000_0001;

endpackage
`default_nettype wire

/* verilog/scwp_top.sv */
// Function
// RULE1 - capture four-bit comparator code during configuration phase; sets master clock rate
// RULE2 - codes 0001/0011/0111 give 1/4/8 MHz; all others 250 kHz
// RULE3 - failed comparator self-test stores slowest 250 kHz configuration
// RULE4 - after configuration phase disable bias, comparators, divider; code frozen
// RULE5 - host runs communication timeout to detect slower-than-intended bit rate
// RULE6 - after isolated link wake, pull sleep/wake pin low 800 ms after reset
// RULE7 - sleep/wake pin filtered by up/reset counter, high accepted after 2 us
// RULE8 - queue-status short reported only after 5 us persistence
// RULE9 - at hold end release pin and start using filtered pin input
// RULE10 - filtered pin high in normal operation raises go-to-sleep request
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module scwp_top
  import scwp_pkg::*;
#(
  parameter int HOLD_COUNT = scwp_pkg::HOLD_CYCLES,
  parameter int FILTER_COUNT = scwp_pkg::FILTER_CYCLES,
  parameter int SHORT_COUNT = scwp_pkg::SHORT_CYCLES
)
(
  // clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // comparator front end
  input wire logic [3:0] COMP_CODE_IN,
  input wire logic COMP_BIST_FAIL_IN,
  output logic RATE_BIAS_EN_OUT,
  // sleep/wake open-drain pin
  input wire logic SLEEP_WAKE_PIN_IN,
  output logic SLEEP_WAKE_PIN_OUT,
  output logic SLEEP_WAKE_PIN_OE_N_OUT,
  // queue-status output short sense
  input wire logic QUEUE_STATUS_FAULT_IN,
  // results
  output scwp_pkg::scwp_rate_t CLOCK_RATE_OUT,
  output logic SLEEP_REQ_OUT,
  output logic QUEUE_STATUS_SHORT_OUT,
  output logic IRQ_OUT
);
  import scwp_pkg::*;

  // ==========================================================================
  // helpers
  // ==========================================================================
  // map a comparator code onto a rate; everything unlisted is slow
  function automatic scwp_rate_t code_to_rate(input logic [3:0] code);
    case (code)
      CODE_1MHZ: code_to_rate = SCWP_RATE_1M; // RULE2
      CODE_4MHZ: code_to_rate = SCWP_RATE_4M; // RULE2
      CODE_8MHZ: code_to_rate = SCWP_RATE_8M; // RULE2
      default: code_to_rate = SCWP_RATE_250K; // RULE2
    endcase
  endfunction

  // saturating up-counter step, used by both filters
  function automatic logic [31:0] count_up(input logic [31:0] cnt, input int limit);
    count_up = (cnt >= 32'(limit)) ? cnt : cnt + 32'h0000_0001;
  endfunction

  // ==========================================================================
  // state and declarations
  // ==========================================================================
  typedef enum logic [2:0]
  {
    SCWP_CAPTURE = 3'b001,
    SCWP_HOLD = 3'b010,
    SCWP_NORMAL = 3'b100
  } scwp_state_t;

  scwp_state_t state;
  logic [31:0] config_reg;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic [3:0] latched_code;
  logic bist_failed;
  logic [1:0] pin_sync;
  logic [1:0] fault_sync;
  logic [31:0] hold_cnt;
  logic [31:0] filt_cnt;
  logic [31:0] short_cnt;
  logic pin_high;
  logic short_seen;
  logic sleep_req;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic phase_done;
  logic hold_done;
  logic [IRQ_WIDTH-1:0] irq_events;
  logic [31:0] state_word;

  assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & CE_IN;
  assign apb_rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN & CE_IN;
  assign addr_ok = (PADDR_IN == REG_CONFIG) | (PADDR_IN == REG_STATE) |
                   (PADDR_IN == REG_IRQ_STATUS) | (PADDR_IN == REG_IRQ_MASK);
  // software ends the configuration phase by clearing the phase bit
  assign phase_done = (state == SCWP_CAPTURE) & ~config_reg[CFG_PHASE_BIT];
  assign hold_done = (state == SCWP_HOLD) & (hold_cnt >= 32'(HOLD_COUNT - 1));

  // ==========================================================================
  // input synchronisers
  // ==========================================================================
  // two flops; only the second stage feeds logic
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
    begin
      pin_sync <= 2'h3;
      fault_sync <= 2'h0;
    end
    else if (CE_IN)
    begin
      pin_sync <= {pin_sync[0], SLEEP_WAKE_PIN_IN};
      fault_sync <= {fault_sync[0], QUEUE_STATUS_FAULT_IN};
    end
  end

  // ==========================================================================
  // phase control
  // ==========================================================================
  // capture -> (hold if woken by the link) -> normal
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
      state <= SCWP_CAPTURE;
    else if (CE_IN)
    begin
      case (state)
        SCWP_CAPTURE:
          if (phase_done)
            state <= config_reg[CFG_ISO_WAKE_BIT] ? SCWP_HOLD : SCWP_NORMAL;
        SCWP_HOLD:
          if (hold_done)
            state <= SCWP_NORMAL; // RULE9
        SCWP_NORMAL:
          state <= SCWP_NORMAL;
        default:
          state <= SCWP_CAPTURE;
      endcase
    end
  end

  // ==========================================================================
  // comparator code capture
  // ==========================================================================
  // the code follows the comparators only while capturing, then is frozen
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
    begin
      latched_code <= CODE_SLOW;
      bist_failed <= 1'b0;
    end
    else if (CE_IN && state == SCWP_CAPTURE) // RULE4
    begin
      latched_code <= COMP_BIST_FAIL_IN ? CODE_SLOW : COMP_CODE_IN; // RULE1 RULE3
      bist_failed <= COMP_BIST_FAIL_IN; // RULE3
    end
  end

  // bias, comparators and divider are off outside the capture phase
  assign RATE_BIAS_EN_OUT = (state == SCWP_CAPTURE); // RULE4

  // rate output is registered from the frozen code
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
      CLOCK_RATE_OUT <= SCWP_RATE_250K;
    else if (CE_IN)
      CLOCK_RATE_OUT <= code_to_rate(latched_code); // RULE1 RULE2
  end

  // ==========================================================================
  // wake notification hold
  // ==========================================================================
  // counts from the end of capture, which follows the main reset release
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
      hold_cnt <= 32'h0000_0000;
    else if (CE_IN && state == SCWP_HOLD)
      hold_cnt <= hold_cnt + 32'h0000_0001; // RULE6
  end

  // open drain: only ever drive low; oe_n low means driving
  assign SLEEP_WAKE_PIN_OUT = 1'b0;
  assign SLEEP_WAKE_PIN_OE_N_OUT = ~(state == SCWP_HOLD); // RULE6 RULE9

  // ==========================================================================
  // sleep pin deglitch
  // ==========================================================================
  // masked until normal state so our own pulldown never looks like a request
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
    begin
      filt_cnt <= 32'h0000_0000;
      pin_high <= 1'b0;
    end
    else if (CE_IN)
    begin
      if (state != SCWP_NORMAL || !pin_sync[1])
      begin
        filt_cnt <= 32'h0000_0000; // RULE7
        pin_high <= 1'b0;
      end
      else
      begin
        filt_cnt <= count_up(filt_cnt, FILTER_COUNT); // RULE7
        pin_high <= (filt_cnt >= 32'(FILTER_COUNT - 1)); // RULE7 RULE9
      end
    end
  end

  // once raised, the sleep request stays until reset; sleep is not abortable
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
      sleep_req <= 1'b0;
    else if (CE_IN && pin_high)
      sleep_req <= 1'b1; // RULE10
  end
  assign SLEEP_REQ_OUT = sleep_req;

  // ==========================================================================
  // queue-status short filter
  // ==========================================================================
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
    begin
      short_cnt <= 32'h0000_0000;
      short_seen <= 1'b0;
    end
    else if (CE_IN)
    begin
      if (!fault_sync[1])
      begin
        short_cnt <= 32'h0000_0000;
        short_seen <= 1'b0;
      end
      else
      begin
        short_cnt <= count_up(short_cnt, SHORT_COUNT); // RULE8
        short_seen <= (short_cnt >= 32'(SHORT_COUNT - 1)); // RULE8
      end
    end
  end
  assign QUEUE_STATUS_SHORT_OUT = short_seen;

  // ==========================================================================
  // interrupts
  // ==========================================================================
  assign irq_events = {hold_done, short_seen, pin_high & ~sleep_req};

  // set wins over a simultaneous write-one-to-clear
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
      irq_status <= '0;
    else if (CE_IN)
    begin
      if (apb_wr && PADDR_IN == REG_IRQ_STATUS)
        irq_status <= (irq_status & ~PWDATA_IN[IRQ_WIDTH-1:0]) | irq_events;
      else
        irq_status <= irq_status | irq_events;
    end
  end
  assign IRQ_OUT = |(irq_status & irq_mask);

  // ==========================================================================
  // apb registers
  // ==========================================================================
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
    begin
      config_reg <= CONFIG_RESET;
      irq_mask <= '0;
    end
    else if (apb_wr)
    begin
      if (PADDR_IN == REG_CONFIG)
        config_reg <= {30'h0, PWDATA_IN[1:0]};
      if (PADDR_IN == REG_IRQ_MASK)
        irq_mask <= PWDATA_IN[IRQ_WIDTH-1:0];
    end
  end

  assign state_word = {22'h0, short_seen, pin_sync[1], (state == SCWP_HOLD),
                       bist_failed, CLOCK_RATE_OUT, latched_code};

  // read data registered; single access cycle, zero wait states
  always_ff @(posedge CLOCK_IN)
  begin
    if (!NRST_IN)
      PRDATA_OUT <= 32'h0000_0000;
    else if (CE_IN && PSEL_IN && !PENABLE_IN && !PWRITE_IN)
    begin
      case (PADDR_IN)
        REG_CONFIG: PRDATA_OUT <= config_reg;
        REG_STATE: PRDATA_OUT <= state_word;
        REG_IRQ_STATUS: PRDATA_OUT <= {29'h0, irq_status};
        REG_IRQ_MASK: PRDATA_OUT <= {29'h0, irq_mask};
        default: PRDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end

  // frozen clock enable stalls the bus too
  assign PREADY_OUT = CE_IN;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;

endmodule
`default_nettype wire
